// *** include/ldcop_map.svh ***
`ifndef LDCOP_MAP_SVH
`define LDCOP_MAP_SVH
// Opcode word values
`define LDCOP_OPC_CEQ      16'hC343
`define LDCOP_OPC_CNE      16'hC342
`define LDCOP_OPC_CGE      16'hC344
`define LDCOP_OPC_CGT      16'hC345
`define LDCOP_OPC_CLE      16'hC341
`define LDCOP_OPC_CLT      16'hC340
`define LDCOP_OPC_AEQ      16'hC10B
`define LDCOP_OPC_FALSE    16'hC10E
`define LDCOP_OPC_FEQ      16'hC24B
`define LDCOP_OPC_FGE      16'hC24C
`define LDCOP_OPC_FLE      16'hC249
// Condition code field: bit 1 = less, bit 0 = equal
`define LDCOP_CC_EQ        2'h1
`define LDCOP_CC_NE        2'h0
`define LDCOP_CC_LT        2'h2
// Character step and register-file addressing
`define LDCOP_CHAR_STEP    32'h00000008
`define LDCOP_RF_ABS_MASK  16'h0000
`define LDCOP_RF_REL_MASK  16'h000F
`define LDCOP_RF_UPPER     8'h10
`define LDCOP_RF_SET_SHIFT 5
// Reset values
`define LDCOP_RST_WORD     16'h0000
`define LDCOP_RST_LONG     32'h00000000
`define LDCOP_RST_CC       2'h0
`endif

// *** include/ldcop_pkg.sv ***
`default_nettype none
package ldcop_pkg;
  typedef enum logic [4:0] {
    LDCOP_NOP,
    LDCOP_JUMP_SAVE_Y,
    LDCOP_CC_EQ,
    LDCOP_CC_NE,
    LDCOP_CC_GE,
    LDCOP_CC_GT,
    LDCOP_CC_LE,
    LDCOP_CC_LT,
    LDCOP_LOAD_ACCUM,
    LDCOP_LOAD_CHAR,
    LDCOP_LOAD_LONG,
    LDCOP_LOAD_RF,
    LDCOP_LOAD_INDEX,
    LDCOP_LOAD_Y,
    LDCOP_AEQ,
    LDCOP_LOAD_FALSE,
    LDCOP_FEQ,
    LDCOP_FGE,
    LDCOP_FGT,
    LDCOP_FLE,
    LDCOP_FLI
  } ldcop_op_t;
  typedef enum {
    LDCOP_IDLE,
    LDCOP_BUSY
  } ldcop_state_t;
endpackage
`default_nettype wire

// *** rtl/ldcop_core.sv ***
// Overview of operation
// RL1 - Jump-save-Y copies word number of PC into Y, PC gets address.
// RL2 - Equal/not-equal condition loads put 1 or 0 in A.
// RL3 - Greater-or-equal condition load sets A from condition codes.
// RL4 - Greater condition load sets A from condition codes.
// RL5 - Less-or-equal condition load sets A from condition codes.
// RL6 - Less condition load sets A from condition codes.
// RL7 - Accumulator load puts memory word into A, flags untouched.
// RL8 - Character load with nonzero length puts byte low, clears high byte.
// RL9 - Character load advances address by 8, length minus one, codes NE.
// RL10 - Zero length character load sets codes to EQ, carry kept.
// RL11 - Length register zero pairs with address zero, one with one.
// RL12 - Long load puts 32-bit doubleword into L.
// RL13 - Absolute register-file load ignores bits 1 and 3-9 of address.
// RL14 - Set-relative register-file load uses bits 13-16, bit 12 group.
// RL15 - Index load fills X; R mode base 2 or 3 skips 16 bits.
// RL16 - Y load puts memory word into Y without indexing.
// RL17 - A-zero test puts 1 or 0 in A, codes from compare.
// RL18 - Load false clears A and sets codes as a compare.
// RL19 - Float zero test loads A from floating accumulator equality.
// RL20 - Float nonnegative test loads A from sign, positive test from sign and zero.
// RL21 - Float nonpositive test loads A and updates codes.
// RL22 - Length immediate copies 16-bit word, clears upper bits.
// RL23 - Zero compares treat operands as signed values.
`timescale 1ns/10ps
`default_nettype none
`include "ldcop_map.svh"
module ldcop_core
  import ldcop_pkg::*;
(
  // Clock and reset
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_IN,
  // Wishbone slave
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [3:0]  WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output logic      [31:0] WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  // Core execution request
  input  wire logic        EXEC_IN,
  input  wire logic [4:0]  OP_IN,
  input  wire logic [31:0] EA_IN,
  input  wire logic [31:0] MEM_IN,
  input  wire logic [15:0] IMM_IN,
  input  wire logic        FLR_SEL_IN,
  input  wire logic        R_MODE_IN,
  input  wire logic [1:0]  BASE_SEL_IN,
  input  wire logic        CARRY_IN,
  input  wire logic        LINK_IN,
  input  wire logic [31:0] F_IN,
  input  wire logic [31:0] RF_DATA_IN,
  // Results
  output logic      [15:0] A_OUT,
  output logic      [31:0] L_OUT,
  output logic      [15:0] X_OUT,
  output logic      [15:0] Y_OUT,
  output logic      [31:0] PC_OUT,
  output logic      [1:0]  CC_OUT,
  output logic             CARRY_OUT,
  output logic             LINK_OUT,
  output logic      [7:0]  RF_ADR_OUT,
  output logic             SKIP16_OUT,
  output logic             DONE_OUT
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Signed compare against zero: {less, equal}
  function automatic logic [1:0] cmp_zero(input logic [31:0] v);
    cmp_zero = {v[31], (v == 32'h00000000)};
  endfunction
  function automatic logic [15:0] bool16(input logic b);
    bool16 = b ? 16'h0001 : 16'h0000;
  endfunction
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] a_reg, a_next;
  logic [31:0] l_reg, l_next;
  logic [15:0] x_reg, x_next;
  logic [15:0] y_reg, y_next;
  logic [31:0] pc_reg, pc_next;
  logic [1:0]  cc_reg, cc_next;
  logic        carry_reg;
  logic        link_reg;
  logic [31:0] flr_reg [2];
  logic [31:0] far_reg [2];
  logic [7:0]  rf_adr_reg, rf_adr_next;
  logic        skip_reg, skip_next;
  logic        done_reg;
  logic [31:0] wb_dat_reg;
  logic        wb_ack_reg;
  ldcop_op_t   op;
  assign op = ldcop_op_t'(OP_IN);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire        cc_less    = cc_reg[1];
  wire        cc_equal   = cc_reg[0];
  wire [1:0]  a_cmp      = cmp_zero({a_reg, 16'h0000});
  wire [1:0]  f_cmp      = cmp_zero(F_IN);
  // RL11 fixed pairing
  wire        sel        = FLR_SEL_IN;
  wire [31:0] flr_cur    = flr_reg[sel];
  wire [31:0] far_cur    = far_reg[sel];
  wire        flr_zero   = (flr_cur == 32'h00000000);
  wire        do_char    = EXEC_IN && (op == LDCOP_LOAD_CHAR) && !flr_zero;
  wire        do_fli     = EXEC_IN && (op == LDCOP_FLI);
  // Byte select: far bit 3 chooses odd byte of the word
  wire [7:0]  char_byte  = far_cur[3] ? MEM_IN[7:0] : MEM_IN[15:8];
  // RL13 absolute form keeps bits 2 and 10-16 only
  wire [7:0]  rf_abs     = {EA_IN[14], EA_IN[6:0]};
  // RL14 set-relative forms
  wire [7:0]  rf_rel     = (EA_IN[4] ? `LDCOP_RF_UPPER : 8'h00)
                           | {4'h0, EA_IN[3:0]};
  wire [7:0]  rf_sel     = EA_IN[14] ? rf_abs : rf_rel;
  // ----------------------------------------
  // Execute
  // ----------------------------------------
  always_comb begin
    a_next      = a_reg;
    l_next      = l_reg;
    x_next      = x_reg;
    y_next      = y_reg;
    pc_next     = pc_reg;
    cc_next     = cc_reg;
    rf_adr_next = rf_adr_reg;
    skip_next   = 1'b0;
    if (EXEC_IN) begin
      case (op)
        // RL1 word number only
        LDCOP_JUMP_SAVE_Y: begin
          y_next  = pc_reg[15:0];
          pc_next = EA_IN;
        end
        // RL2 equality sense
        LDCOP_CC_EQ: a_next = bool16(cc_equal);
        LDCOP_CC_NE: a_next = bool16(!cc_equal);
        // RL3 ge from codes
        LDCOP_CC_GE: a_next = bool16(!cc_less);
        // RL4 strictly greater
        LDCOP_CC_GT: a_next = bool16(!cc_less && !cc_equal);
        // RL5 less or equal
        LDCOP_CC_LE: a_next = bool16(cc_less || cc_equal);
        // RL6 strictly less
        LDCOP_CC_LT: a_next = bool16(cc_less);
        // RL7 memory to A
        LDCOP_LOAD_ACCUM: a_next = MEM_IN[15:0];
        LDCOP_LOAD_CHAR: begin
          if (!flr_zero) begin
            // RL8 byte placed low
            a_next  = {8'h00, char_byte};
            // RL9 codes to not-equal
            cc_next = `LDCOP_CC_NE;
          end else begin
            // RL10 empty field
            cc_next = `LDCOP_CC_EQ;
          end
        end
        // RL12 full doubleword
        LDCOP_LOAD_LONG: l_next = MEM_IN;
        LDCOP_LOAD_RF: begin
          rf_adr_next = rf_sel;
          l_next      = RF_DATA_IN;
          // RL14 codes left undefined, hold
          cc_next     = cc_reg;
        end
        LDCOP_LOAD_INDEX: begin
          x_next    = MEM_IN[15:0];
          // RL15 skip on base 2 or 3
          skip_next = R_MODE_IN && BASE_SEL_IN[1];
        end
        // RL16 memory to Y
        LDCOP_LOAD_Y: y_next = MEM_IN[15:0];
        // RL17 A-zero test, RL23 signed
        LDCOP_AEQ: begin
          a_next  = bool16(a_cmp[0]);
          cc_next = a_cmp;
        end
        // RL18 unconditional zero
        LDCOP_LOAD_FALSE: begin
          a_next  = 16'h0000;
          cc_next = a_cmp;
        end
        // RL19 float equal zero
        LDCOP_FEQ: begin
          a_next  = bool16(f_cmp[0]);
          cc_next = f_cmp;
        end
        // RL20 nonnegative
        LDCOP_FGE: begin
          a_next  = bool16(!f_cmp[1]);
          cc_next = f_cmp;
        end
        // RL20 strictly positive
        LDCOP_FGT: begin
          a_next  = bool16(!f_cmp[1] && !f_cmp[0]);
          cc_next = f_cmp;
        end
        // RL21 nonpositive
        LDCOP_FLE: begin
          a_next  = bool16(f_cmp[1] || f_cmp[0]);
          cc_next = f_cmp;
        end
        default: a_next = a_reg;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      a_reg      <= `LDCOP_RST_WORD;
      l_reg      <= `LDCOP_RST_LONG;
      x_reg      <= `LDCOP_RST_WORD;
      y_reg      <= `LDCOP_RST_WORD;
      pc_reg     <= `LDCOP_RST_LONG;
      cc_reg     <= `LDCOP_RST_CC;
      rf_adr_reg <= 8'h00;
      skip_reg   <= 1'b0;
      done_reg   <= 1'b0;
      carry_reg  <= 1'b0;
      link_reg   <= 1'b0;
    end else begin
      a_reg      <= a_next;
      l_reg      <= l_next;
      x_reg      <= x_next;
      y_reg      <= y_next;
      pc_reg     <= pc_next;
      cc_reg     <= cc_next;
      rf_adr_reg <= rf_adr_next;
      skip_reg   <= skip_next;
      done_reg   <= EXEC_IN;
      // Carry and link are never altered by this group
      carry_reg  <= CARRY_IN;
      link_reg   <= LINK_IN;
    end
  end

  // ----------------------------------------
  // Field registers and bus
  // ----------------------------------------
  // Word offsets: 0/1 length, 2/3 address
  wire        wb_req = WB_CYC_IN && WB_STB_IN && !wb_ack_reg;
  wire        wb_wr  = wb_req && WB_WE_IN;
  wire [31:0] wb_rd  = (WB_ADR_IN == 4'h0) ? flr_reg[0] :
                       (WB_ADR_IN == 4'h1) ? flr_reg[1] :
                       (WB_ADR_IN == 4'h2) ? far_reg[0] :
                       (WB_ADR_IN == 4'h3) ? far_reg[1] :
                       (WB_ADR_IN == 4'h4) ? {30'h0, cc_reg} :
                       32'h00000000;

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : o[i*8 +: 8];
  endfunction

  // Core updates win over a bus write in the same cycle
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      flr_reg[0] <= `LDCOP_RST_LONG;
      flr_reg[1] <= `LDCOP_RST_LONG;
      far_reg[0] <= `LDCOP_RST_LONG;
      far_reg[1] <= `LDCOP_RST_LONG;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wb_wr && WB_ADR_IN == 4'(i))
          flr_reg[i] <= merge(flr_reg[i], WB_DAT_IN, WB_SEL_IN);
        if (wb_wr && WB_ADR_IN == 4'(i + 2))
          far_reg[i] <= merge(far_reg[i], WB_DAT_IN, WB_SEL_IN);
      end
      // RL9 advance address, shorten field
      if (do_char) begin
        far_reg[sel] <= far_cur + `LDCOP_CHAR_STEP;
        flr_reg[sel] <= flr_cur - 32'h00000001;
      end
      // RL22 zero-extended immediate
      if (do_fli)
        flr_reg[sel] <= {16'h0000, IMM_IN};
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= `LDCOP_RST_LONG;
    end else begin
      wb_ack_reg <= wb_req;
      wb_dat_reg <= wb_req ? wb_rd : wb_dat_reg;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign A_OUT      = a_reg;
  assign L_OUT      = l_reg;
  assign X_OUT      = x_reg;
  assign Y_OUT      = y_reg;
  assign PC_OUT     = pc_reg;
  assign CC_OUT     = cc_reg;
  assign CARRY_OUT  = carry_reg;
  assign LINK_OUT   = link_reg;
  assign RF_ADR_OUT = rf_adr_reg;
  assign SKIP16_OUT = skip_reg;
  assign DONE_OUT   = done_reg;
  assign WB_ACK_OUT = wb_ack_reg;
  assign WB_DAT_OUT = wb_dat_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_jump_save;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (EXEC_IN && op == LDCOP_JUMP_SAVE_Y) |=>
        (Y_OUT == $past(pc_reg[15:0]) && PC_OUT == $past(EA_IN));
  endproperty
  a_jump_save: assert property (p_jump_save) else $error("jump save wrong"); // RL1
  property p_ceq;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (EXEC_IN && op == LDCOP_CC_EQ) |=>
        (A_OUT == {15'h0, $past(cc_reg[0])} && $stable(CC_OUT));
  endproperty
  a_ceq: assert property (p_ceq) else $error("ceq wrong"); // RL2
  property p_cgt;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (EXEC_IN && op == LDCOP_CC_GT && cc_reg == `LDCOP_CC_NE)
        |=> A_OUT == 16'h0001;
  endproperty
  a_cgt: assert property (p_cgt) else $error("cgt wrong"); // RL4
  property p_clt;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (EXEC_IN && op == LDCOP_CC_LT) |=> A_OUT == {15'h0, $past(cc_reg[1])};
  endproperty
  a_clt: assert property (p_clt) else $error("clt wrong"); // RL6
  property p_char;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
      do_char |=> (A_OUT[15:8] == 8'h00 && CC_OUT == `LDCOP_CC_NE
                   && far_reg[$past(sel)] == $past(far_cur) + 32'h8);
  endproperty
  a_char: assert property (p_char) else $error("char wrong"); // RL9
  property p_char0;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (EXEC_IN && op == LDCOP_LOAD_CHAR && flr_zero) |=>
        CC_OUT == `LDCOP_CC_EQ;
  endproperty
  a_char0: assert property (p_char0) else $error("char0 wrong"); // RL10
  property p_load_false;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (EXEC_IN && op == LDCOP_LOAD_FALSE) |=> A_OUT == 16'h0000;
  endproperty
  a_load_false: assert property (p_load_false) else $error("false wrong"); // RL18
  property p_fge;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (EXEC_IN && op == LDCOP_FGE) |=> A_OUT == {15'h0, !$past(F_IN[31])};
  endproperty
  a_fge: assert property (p_fge) else $error("fge wrong"); // RL20
  property p_fli;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
      do_fli |=> flr_reg[$past(sel)] == {16'h0, $past(IMM_IN)};
  endproperty
  a_fli: assert property (p_fli) else $error("fli wrong"); // RL22
endmodule

`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import ldcop_pkg::*;
;
  // ----------------------------------------
  // Bench signals and design
  // ----------------------------------------
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, exec = 1'b0;
  logic [3:0]  adr = 4'h0, bsel = 4'h0;
  logic [31:0] wdat = 32'h0, ea = 32'h0, mem = 32'h0, f = 32'h0;
  logic [31:0] rf = 32'h0, mem_v = 32'h0, f_v = 32'h0;
  logic [31:0] seed = 32'h0000A133;
  logic [15:0] imm = 16'h0;
  logic [4:0]  op = 5'h0;
  logic [1:0]  bs = 2'h0, bs_v = 2'h0;
  logic        fsel = 1'b0, rm = 1'b0, cy = 1'b0, lk = 1'b0;
  logic        sel_v = 1'b0, rm_v = 1'b0;
  wire  [31:0] rdat, l_o, pc_o;
  wire  [15:0] a_o, x_o, y_o;
  wire  [7:0]  ra_o;
  wire  [1:0]  cc_o;
  wire         ack, cy_o, lk_o, sk_o, done;
  // Reference state, integers only
  logic [15:0] m_a = 16'h0, m_x = 16'h0, m_y = 16'h0;
  logic [31:0] m_l = 32'h0, m_pc = 32'h0;
  logic [31:0] m_flr [2] = '{32'h0, 32'h0};
  logic [31:0] m_far [2] = '{32'h0, 32'h0};
  logic [1:0]  m_cc = 2'h0;
  int          fails = 0, checks_done = 0;
  int          i, j;

  ldcop_core u_ldcop_core (
    .SYS_CLK_IN (sys_clk), .RST_IN (rst),
    .WB_CYC_IN (cyc), .WB_STB_IN (stb), .WB_WE_IN (we),
    .WB_ADR_IN (adr), .WB_SEL_IN (bsel), .WB_DAT_IN (wdat),
    .WB_DAT_OUT (rdat), .WB_ACK_OUT (ack),
    .EXEC_IN (exec), .OP_IN (op), .EA_IN (ea), .MEM_IN (mem),
    .IMM_IN (imm), .FLR_SEL_IN (fsel), .R_MODE_IN (rm),
    .BASE_SEL_IN (bs), .CARRY_IN (cy), .LINK_IN (lk), .F_IN (f),
    .RF_DATA_IN (rf), .A_OUT (a_o), .L_OUT (l_o), .X_OUT (x_o),
    .Y_OUT (y_o), .PC_OUT (pc_o), .CC_OUT (cc_o), .CARRY_OUT (cy_o),
    .LINK_OUT (lk_o), .RF_ADR_OUT (ra_o), .SKIP16_OUT (sk_o),
    .DONE_OUT (done)
  );

  always #50 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic complete_run();
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Holds the request until ack is seen at an edge or 20 more edges pass, no fixed latency
  task automatic wb_cycle(input logic w, input logic [3:0] a,
                          input logic [3:0] s, input logic [31:0] d,
                          output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    bsel <= s;
    wdat <= d;
    @(posedge sys_clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, ack}, 32'h1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    logic [31:0] q;
    int          k;
    wb_cycle(1'b1, a, s, d, q);
    for (k = 0; k < 4; k++) begin
      if (s[k] && a < 4'h2) m_flr[a[0]][8*k +: 8] = d[8*k +: 8];
      if (s[k] && (a == 4'h2 || a == 4'h3)) m_far[a[0]][8*k +: 8] = d[8*k +: 8];
    end
  endtask

  // Unmapped word 'hA must read back as zero
  task automatic check_regs();
    logic [31:0] q, e;
    logic [3:0]  a;
    int          k;
    for (k = 0; k < 6; k++) begin
      a = (k == 5) ? 4'hA : k[3:0];
      e = (k < 2) ? m_flr[a[0]] : (k < 4) ? m_far[a[0]] : 32'h0;
      if (k == 4) e = {30'h0, m_cc};
      wb_cycle(1'b0, a, 4'hF, 32'h0, q);
      chk(q, e);
    end
  endtask

  task automatic check_state();
    chk({16'h0, a_o}, {16'h0, m_a});
    chk(l_o, m_l);
    chk({x_o, y_o}, {m_x, m_y});
    chk(pc_o, m_pc);
    chk({30'h0, cc_o}, {30'h0, m_cc});
  endtask

  task automatic exec_op(input logic [4:0] o);
    logic [31:0] e, r, k;
    logic [7:0]  ra, b;
    logic        sk;
    int          n;
    e = rnd();
    r = rnd();
    k = rnd();
    sk = 1'b0;
    ra = e[14] ? {1'b1, e[6:0]} : {3'h0, e[4:0]};
    b = m_far[sel_v][3] ? mem_v[7:0] : mem_v[15:8];
    case (o)
      LDCOP_JUMP_SAVE_Y: begin
        m_y = m_pc[15:0];
        m_pc = e;
      end
      LDCOP_LOAD_ACCUM: m_a = mem_v[15:0];
      LDCOP_LOAD_LONG: m_l = mem_v;
      LDCOP_LOAD_Y: m_y = mem_v[15:0];
      LDCOP_LOAD_RF: m_l = r;
      LDCOP_FLI: m_flr[sel_v] = {16'h0, k[15:0]};
      LDCOP_LOAD_INDEX: begin
        m_x = mem_v[15:0];
        sk = rm_v && bs_v[1];
      end
      LDCOP_LOAD_CHAR: begin
        m_cc = (m_flr[sel_v] == 32'h0) ? 2'h1 : 2'h0;
        if (m_flr[sel_v] != 32'h0) begin
          m_a = {8'h0, b};
          m_far[sel_v] = m_far[sel_v] + 32'h8;
          m_flr[sel_v] = m_flr[sel_v] - 32'h1;
        end
      end
      LDCOP_CC_EQ: m_a = {15'h0, m_cc[0]};
      LDCOP_CC_NE: m_a = {15'h0, !m_cc[0]};
      LDCOP_CC_GE: m_a = {15'h0, !m_cc[1]};
      LDCOP_CC_GT: m_a = {15'h0, !m_cc[1] && !m_cc[0]};
      LDCOP_CC_LE: m_a = {15'h0, m_cc[1] || m_cc[0]};
      LDCOP_CC_LT: m_a = {15'h0, m_cc[1]};
      LDCOP_AEQ, LDCOP_LOAD_FALSE: begin
        m_cc = {m_a[15], m_a == 16'h0};
        m_a = (o == LDCOP_LOAD_FALSE) ? 16'h0 : {15'h0, m_a == 16'h0};
      end
      default: begin
        m_cc = {f_v[31], f_v == 32'h0};
        m_a = {15'h0, (o == LDCOP_FEQ) ? m_cc[0] : (o == LDCOP_FGE) ?
               !m_cc[1] : (o == LDCOP_FGT) ? !m_cc[1] && !m_cc[0] :
               m_cc[1] || m_cc[0]};
      end
    endcase
    @(posedge sys_clk);
    exec <= 1'b1;
    op <= o;
    ea <= e;
    mem <= mem_v;
    f <= f_v;
    rf <= r;
    imm <= k[15:0];
    fsel <= sel_v;
    rm <= rm_v;
    bs <= bs_v;
    cy <= k[16];
    lk <= k[17];
    @(posedge sys_clk);
    exec <= 1'b0;
    n = 0;
    @(posedge sys_clk);
    while (done !== 1'b1 && n < 8) begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, done}, 32'h1);
    check_state();
    chk({30'h0, cy_o, lk_o}, {30'h0, k[16], k[17]});
    chk({31'h0, sk_o}, {31'h0, sk});
    if (o == LDCOP_LOAD_RF) chk({24'h0, ra_o}, {24'h0, ra});
  endtask

  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check_state();
    check_regs();
    wr(4'h0, 4'hF, 32'h3);
    wr(4'h1, 4'hF, 32'h2);
    wr(4'h2, 4'hF, 32'h100);
    wr(4'h3, 4'hF, 32'h208);
    wr(4'h3, 4'h1, 32'hFFFFFF30);
    // Status word is read-only, writes must vanish
    wr(4'h4, 4'hF, 32'hFFFFFFFF);
    wr(4'hA, 4'hF, 32'h12345678);
    check_regs();
    for (i = 0; i < 9; i++) begin
      sel_v = i[0];
      mem_v = rnd();
      exec_op(LDCOP_LOAD_CHAR);
      if (i == 7) check_regs();
      if (i == 7) exec_op(LDCOP_FLI);
    end
    check_regs();
    for (i = 0; i < 8; i++) begin
      mem_v = rnd();
      rm_v = i[2];
      bs_v = i[1:0];
      exec_op(LDCOP_LOAD_ACCUM);
      exec_op(LDCOP_LOAD_LONG);
      exec_op(LDCOP_LOAD_INDEX);
      exec_op(LDCOP_LOAD_Y);
      exec_op(LDCOP_LOAD_RF);
      exec_op(LDCOP_JUMP_SAVE_Y);
    end
    for (i = 0; i < 3; i++) begin
      mem_v = (i == 0) ? 32'h0 : (i == 1) ? 32'h5 : 32'h8000;
      exec_op(LDCOP_LOAD_ACCUM);
      exec_op(LDCOP_AEQ);
      for (j = LDCOP_CC_EQ; j <= LDCOP_CC_LT; j++) exec_op(5'(j));
      exec_op(LDCOP_LOAD_FALSE);
      f_v = (i == 0) ? 32'h0 : (i == 1) ? 32'h1 : 32'h80000001;
      for (j = LDCOP_FEQ; j <= LDCOP_FLE; j++) exec_op(5'(j));
    end
    complete_run();
  end
endmodule
`default_nettype wire
